// ===== shared/dpram_host_defines.svh
`ifndef DPRAM_HOST_DEFINES_SVH
`define DPRAM_HOST_DEFINES_SVH

// Widths of the memory port and the software bus.
`define MEM_ADDR_W 17
`define MEM_DATA_W 9
`define APB_ADDR_W 12
`define APB_DATA_W 32

// Register byte offsets.
`define REG_CTRL   12'h000
`define REG_ADDR   12'h004
`define REG_WDATA  12'h008
`define REG_RDATA  12'h00C
`define REG_STATUS 12'h010

// Control register fields.
`define CTRL_START     0
`define CTRL_OP_LSB    1
`define CTRL_OP_MSB    3
`define CTRL_SECONDARY 4
`define CTRL_ABORT     5

// Status register fields.
`define STAT_RUNNING    0
`define STAT_DONE       1
`define STAT_OWNED      2
`define STAT_CONTENTION 3
`define STAT_MAILBOX    4

// Token write value that requests a latch.
`define TOKEN_REQUEST 9'h000

// Timing in nanoseconds and the derived clock counts.
`define CLK_PERIOD_NS           20
`define CYC_UP(ns)              (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CROSS_PORT_SETTLE_NS    35
`define CROSS_PORT_SETTLE_CYC   `CYC_UP(`CROSS_PORT_SETTLE_NS)
`define MATCH_FLAG_DELAY_NS     20
`define MATCH_FLAG_DELAY_CYC    `CYC_UP(`MATCH_FLAG_DELAY_NS)
`define TOKEN_UPDATE_GAP_NS     12
`define TOKEN_UPDATE_GAP_CYC    `CYC_UP(`TOKEN_UPDATE_GAP_NS)
`define WRITE_PULSE_NS          22
`define WRITE_PULSE_CYC         `CYC_UP(`WRITE_PULSE_NS)
`define TOKEN_ACCESS_NS         25
`define TOKEN_ACCESS_CYC        `CYC_UP(`TOKEN_ACCESS_NS)

`endif

// ===== shared/dpram_host_pkg.sv
`include "dpram_host_defines.svh"

package dpram_host_pkg;

    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_SETTLE = 4'h2,
        ST_STROBE = 4'h4,
        ST_GAP    = 4'h8
    } seq_state_t;

    // Operations that software may order.
    typedef enum logic [2:0] {
        OP_MEM_READ      = 3'h0,
        OP_MEM_WRITE     = 3'h1,
        OP_TOKEN_READ    = 3'h2,
        OP_TOKEN_WRITE   = 3'h3,
        OP_TOKEN_ACQUIRE = 3'h4
    } op_t;

    // Everything the controller drives towards one memory port.
    typedef struct packed {
        logic [`MEM_ADDR_W-1:0] addr;
        logic                   mem_select_n;
        logic                   token_latch_select_n;
        logic                   read_not_write;
        logic                   output_drive_n;
        logic [`MEM_DATA_W-1:0] dq_out;
        logic                   dq_oe;
    } pin_drive_t;

    // Orders from the register file to the sequencer.
    typedef struct packed {
        logic                   start;
        op_t                    op;
        logic                   secondary;
        logic                   abort;
        logic [`MEM_ADDR_W-1:0] addr;
        logic [`MEM_DATA_W-1:0] wdata;
    } cmd_t;

    // State reported back to software.
    typedef struct packed {
        logic                   running;
        logic                   done;
        logic                   owned;
        logic                   contention;
        logic                   mailbox;
        logic [`MEM_DATA_W-1:0] rdata;
    } report_t;

endpackage

// ===== rtl/cmd_regs.sv
`timescale 1ns/1ns
`include "dpram_host_defines.svh"

module cmd_regs (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`APB_ADDR_W-1:0]   paddr,
    input  wire logic [`APB_DATA_W-1:0]   pwdata,
    output logic      [`APB_DATA_W-1:0]   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire dpram_host_pkg::report_t  report,
    output dpram_host_pkg::cmd_t          cmd
);
    logic                   pready_reg;
    logic [`APB_DATA_W-1:0] prdata_reg;
    logic                   pslverr_reg;
    logic                   access;
    dpram_host_pkg::cmd_t   cmd_reg;

    // Known offsets answer normally; anything else raises pslverr.
    function automatic logic reg_known(input logic [`APB_ADDR_W-1:0] a);
        return (a == `REG_CTRL) || (a == `REG_ADDR) || (a == `REG_WDATA) ||
               (a == `REG_RDATA) || (a == `REG_STATUS);
    endfunction

    // Read mux, used when the setup cycle is seen.
    function automatic logic [`APB_DATA_W-1:0] read_mux(input logic [`APB_ADDR_W-1:0] a,
                                                        input dpram_host_pkg::report_t r,
                                                        input dpram_host_pkg::cmd_t c);
        logic [`APB_DATA_W-1:0] v;
        v = '0;
        case (a)
            `REG_CTRL:
            begin
                v[`CTRL_OP_MSB:`CTRL_OP_LSB] = c.op;
                v[`CTRL_SECONDARY]           = c.secondary;
            end
            `REG_ADDR:   v[`MEM_ADDR_W-1:0] = c.addr;
            `REG_WDATA:  v[`MEM_DATA_W-1:0] = c.wdata;
            `REG_RDATA:  v[`MEM_DATA_W-1:0] = r.rdata;
            `REG_STATUS:
            begin
                v[`STAT_RUNNING]    = r.running;
                v[`STAT_DONE]       = r.done;
                v[`STAT_OWNED]      = r.owned;
                v[`STAT_CONTENTION] = r.contention;
                v[`STAT_MAILBOX]    = r.mailbox;
            end
            default: v = '0;
        endcase
        return v;
    endfunction

    assign access  = psel && penable && pready_reg;
    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign cmd     = cmd_reg;

    // Every transfer gets exactly one wait state, so the answer is always a flop.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready_reg <= 1'b0;
        else
            pready_reg <= psel && penable && !pready_reg;
    end

    // Read data and error are captured at setup and held through the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= '0;
            pslverr_reg <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_reg  <= pwrite ? '0 : read_mux(paddr, report, cmd_reg);
            pslverr_reg <= !reg_known(paddr);
        end
    end

    // Writes land only at the completing edge; start and abort are one-cycle pulses.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cmd_reg <= '0;
        else
        begin
            cmd_reg.start <= access && pwrite && (paddr == `REG_CTRL) && pwdata[`CTRL_START];
            cmd_reg.abort <= access && pwrite && (paddr == `REG_CTRL) && pwdata[`CTRL_ABORT];
            if (access && pwrite && (paddr == `REG_CTRL))
            begin
                cmd_reg.op        <= dpram_host_pkg::op_t'(pwdata[`CTRL_OP_MSB:`CTRL_OP_LSB]);
                cmd_reg.secondary <= pwdata[`CTRL_SECONDARY];
            end
            if (access && pwrite && (paddr == `REG_ADDR))
                cmd_reg.addr <= pwdata[`MEM_ADDR_W-1:0];
            if (access && pwrite && (paddr == `REG_WDATA))
                cmd_reg.wdata <= pwdata[`MEM_DATA_W-1:0];
        end
    end

endmodule // cmd_regs

// ===== rtl/dpram_port_ctrl.sv
`timescale 1ns/1ns
`include "dpram_host_defines.svh"

// Function
// R01: Memory read drives port select and output enable low, direction high.
// R02: Device gives each port independent access to every memory location.
// R03: Token cycle asserts token select only; both selects low is forbidden.
// R04: Device drives token value when token select, read and output enable.
// R05: Device floats data and powers down a port with both selects high.
// R06: Reading a location the far port writes waits the cross-port settle time.
// R07: Top word is right port mailbox, next word is left port mailbox.
// R08: Writing the far mailbox pulls the far mailbox interrupt low.
// R09: Reading the own mailbox returns the own interrupt high.
// R10: Reading the far mailbox changes no interrupt.
// R11: Active contention blocks setting and clearing mailbox interrupts for that port.
// R12: Matching addresses within the arbitration window grant exactly one port.
// R13: Contention flag goes active on match or select, clears when contention ends.
// R14: Role pin high drives contention pins, low takes them as inputs.
// R15: Writes to a secondary device wait until its contention input settles.
// R16: Secondary device with active contention input suppresses that port's write.
// R17: Device holds eight shared token latches apart from the memory.
// R18: Token cycles use only the three lowest address lines.
// R19: Token write uses data bit zero; zero requests, one releases.
// R20: The port that wrote zero to a free latch reads zero; other reads one.
// R21: Release with a pending request hands the token to the requester.
// R22: Token read drives all data lines from a held output register.
// R23: Simultaneous requests within the race window give the token to one port.
// R24: After a token write, deselect for the update gap before reading back.
// R25: Requester reads back after writing zero and polls while it reads one.
module dpram_port_ctrl (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`APB_ADDR_W-1:0]   paddr,
    input  wire logic [`APB_DATA_W-1:0]   pwdata,
    output logic      [`APB_DATA_W-1:0]   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output dpram_host_pkg::pin_drive_t    pins,
    input  wire logic [`MEM_DATA_W-1:0]   dq_in,
    input  wire logic                     contention_n,
    input  wire logic                     mailbox_int_n
);
    dpram_host_pkg::cmd_t        cmd;
    dpram_host_pkg::report_t     report;
    dpram_host_pkg::seq_state_t  state_reg;
    dpram_host_pkg::seq_state_t  state_next;
    dpram_host_pkg::op_t         op_reg;
    dpram_host_pkg::op_t         op_next;
    dpram_host_pkg::pin_drive_t  pins_reg;
    dpram_host_pkg::pin_drive_t  pins_next;
    logic [2:0]                  cnt_reg;
    logic [2:0]                  cnt_next;
    logic                        acq_read_reg;
    logic                        acq_read_next;
    logic                        abort_pend_reg;
    logic                        done_reg;
    logic                        owned_reg;
    logic [`MEM_DATA_W-1:0]      rdata_reg;
    logic [`MEM_ADDR_W-1:0]      addr_reg;
    logic [`MEM_DATA_W-1:0]      wdata_reg;
    logic                        capture;
    logic                        finish;

    // Token operations select the latches instead of the memory array.
    function automatic logic op_is_token(input dpram_host_pkg::op_t op);
        return (op == dpram_host_pkg::OP_TOKEN_READ) || (op == dpram_host_pkg::OP_TOKEN_WRITE) ||
               (op == dpram_host_pkg::OP_TOKEN_ACQUIRE);
    endfunction

    // An acquire writes first and reads back afterwards.
    function automatic logic op_writes(input dpram_host_pkg::op_t op, input logic acq_read);
        return (op == dpram_host_pkg::OP_MEM_WRITE) || (op == dpram_host_pkg::OP_TOKEN_WRITE) ||
               ((op == dpram_host_pkg::OP_TOKEN_ACQUIRE) && !acq_read);
    endfunction

    // Strobe length minus one, as loaded into the down counter.
    function automatic logic [2:0] strobe_len(input dpram_host_pkg::op_t op, input logic acq_read);
        if (op_is_token(op))
            return 3'(`TOKEN_ACCESS_CYC - 1);
        else if (op_writes(op, acq_read))
            return 3'(`WRITE_PULSE_CYC - 1);
        else
            return 3'(`CROSS_PORT_SETTLE_CYC - 1); // R06
    endfunction

    cmd_regs u_regs (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .report  (report),
        .cmd     (cmd)
    );

    assign report.running    = (state_reg != dpram_host_pkg::ST_IDLE);
    assign report.done       = done_reg;
    assign report.owned      = owned_reg;
    assign report.contention = !contention_n;
    assign report.mailbox    = !mailbox_int_n;
    assign report.rdata      = rdata_reg;
    assign pins              = pins_reg;

    // Sequencer; a start order outside idle is ignored.
    always_comb
    begin
        state_next    = state_reg;
        op_next       = op_reg;
        acq_read_next = acq_read_reg;
        cnt_next      = (cnt_reg == 3'h0) ? 3'h0 : cnt_reg - 3'h1;
        capture       = 1'b0;
        finish        = 1'b0;
        case (state_reg)
            dpram_host_pkg::ST_IDLE:
            begin
                if (cmd.start)
                begin
                    op_next       = cmd.op;
                    acq_read_next = 1'b0;
                    if ((cmd.op == dpram_host_pkg::OP_MEM_WRITE) && cmd.secondary)
                    begin
                        state_next = dpram_host_pkg::ST_SETTLE;
                        cnt_next   = 3'(`MATCH_FLAG_DELAY_CYC - 1);
                    end
                    else
                    begin
                        state_next = dpram_host_pkg::ST_STROBE;
                        cnt_next   = strobe_len(cmd.op, 1'b0);
                    end
                end
            end
            dpram_host_pkg::ST_SETTLE:
            begin
                // Select without write strobe until the contention input has settled high.
                if (abort_pend_reg)
                begin
                    state_next = dpram_host_pkg::ST_GAP;
                    cnt_next   = 3'(`TOKEN_UPDATE_GAP_CYC - 1);
                end
                else if ((cnt_reg == 3'h0) && contention_n) // R15
                begin
                    state_next = dpram_host_pkg::ST_STROBE;
                    cnt_next   = strobe_len(op_reg, acq_read_reg);
                end
            end
            dpram_host_pkg::ST_STROBE:
            begin
                // A contended memory read restarts its settle wait rather than take bad data.
                if (!op_is_token(op_reg) && !op_writes(op_reg, acq_read_reg) && !contention_n)
                    cnt_next = strobe_len(op_reg, acq_read_reg); // R06
                else if (cnt_reg == 3'h0)
                begin
                    capture    = !op_writes(op_reg, acq_read_reg);
                    state_next = dpram_host_pkg::ST_GAP;
                    cnt_next   = 3'(`TOKEN_UPDATE_GAP_CYC - 1); // R24
                end
            end
            dpram_host_pkg::ST_GAP:
            begin
                if (cnt_reg == 3'h0)
                begin
                    // Acquire reads back after its write and keeps polling while it reads one.
                    if ((op_reg == dpram_host_pkg::OP_TOKEN_ACQUIRE) && !abort_pend_reg &&
                        (!acq_read_reg || rdata_reg[0])) // R25
                    begin
                        acq_read_next = 1'b1;
                        state_next    = dpram_host_pkg::ST_STROBE;
                        cnt_next      = strobe_len(op_reg, 1'b1);
                    end
                    else
                    begin
                        state_next = dpram_host_pkg::ST_IDLE;
                        finish     = 1'b1;
                    end
                end
            end
            default: state_next = dpram_host_pkg::ST_IDLE;
        endcase
    end

    // Pin levels for the coming cycle; every pin is a flop so nothing glitches.
    always_comb
    begin
        pins_next                      = '0;
        pins_next.addr                 = (cmd.start && (state_reg == dpram_host_pkg::ST_IDLE))
                                       ? cmd.addr : addr_reg;
        pins_next.mem_select_n         = 1'b1;
        pins_next.token_latch_select_n = 1'b1;
        pins_next.read_not_write       = 1'b1;
        pins_next.output_drive_n       = 1'b1;
        pins_next.dq_out               = (op_next == dpram_host_pkg::OP_TOKEN_ACQUIRE)
                                       ? `TOKEN_REQUEST : wdata_reg; // R19
        if (state_next == dpram_host_pkg::ST_SETTLE)
            pins_next.mem_select_n = 1'b0;
        if (state_next == dpram_host_pkg::ST_STROBE)
        begin
            if (op_is_token(op_next))
                pins_next.token_latch_select_n = 1'b0; // R03
            else
                pins_next.mem_select_n = 1'b0;
            if (op_writes(op_next, acq_read_next))
            begin
                pins_next.read_not_write = 1'b0;
                pins_next.dq_oe          = 1'b1;
            end
            else
                pins_next.output_drive_n = 1'b0; // R01
        end
    end

    // Write data must be known before the first strobe, so it tracks the register while idle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wdata_reg <= '0;
        else if (state_reg == dpram_host_pkg::ST_IDLE)
            wdata_reg <= cmd.wdata;
    end

    // State, counter and operation registers.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg    <= dpram_host_pkg::ST_IDLE;
            op_reg       <= dpram_host_pkg::OP_MEM_READ;
            cnt_reg      <= 3'h0;
            acq_read_reg <= 1'b0;
            addr_reg     <= '0;
            pins_reg     <= '1;
        end
        else
        begin
            state_reg       <= state_next;
            op_reg          <= op_next;
            cnt_reg         <= cnt_next;
            acq_read_reg    <= acq_read_next;
            addr_reg        <= pins_next.addr;
            pins_reg        <= pins_next;
        end
    end

    // Captured read data; the device holds a token value steady during our sample.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rdata_reg <= '0;
        else if (capture)
            rdata_reg <= dq_in;
    end

    // Status flags: done and ownership follow the sequencer, abort is sticky until start.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_reg       <= 1'b0;
            owned_reg      <= 1'b0;
            abort_pend_reg <= 1'b0;
        end
        else
        begin
            if (finish)
                done_reg <= 1'b1;
            else if (cmd.start && (state_reg == dpram_host_pkg::ST_IDLE))
                done_reg <= 1'b0;
            if (capture && (op_reg == dpram_host_pkg::OP_TOKEN_ACQUIRE))
                owned_reg <= !dq_in[0]; // R20
            else if (cmd.start && (state_reg == dpram_host_pkg::ST_IDLE) && op_is_token(cmd.op))
                owned_reg <= 1'b0;
            if (cmd.abort)
                abort_pend_reg <= 1'b1;
            else if (cmd.start && (state_reg == dpram_host_pkg::ST_IDLE))
                abort_pend_reg <= 1'b0;
        end
    end

    // Checks on the pin sequences.
    sequence tok_write_end;
        $past(!pins.token_latch_select_n && !pins.read_not_write) &&
        !(!pins.token_latch_select_n && !pins.read_not_write);
    endsequence

    sequence acq_reads_one;
        capture && (op_reg == dpram_host_pkg::OP_TOKEN_ACQUIRE) && dq_in[0] && !abort_pend_reg;
    endsequence

    sequence token_read_pins;
        !pins.token_latch_select_n && !pins.output_drive_n && pins.read_not_write;
    endsequence

    read_drive_a: assert property (@(posedge pclk) disable iff (!presetn) // R01
        !pins.output_drive_n |-> pins.read_not_write && !pins.dq_oe &&
            (pins.mem_select_n != pins.token_latch_select_n))
        else $error("read strobe without proper select and direction");

    select_excl_a: assert property (@(posedge pclk) disable iff (!presetn) // R03
        !(!pins.mem_select_n && !pins.token_latch_select_n))
        else $error("memory and token selects both low");

    settle_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R06
        (capture && !op_is_token(op_reg)) |->
            !pins.output_drive_n && $past(!pins.output_drive_n) && contention_n)
        else $error("memory read sampled before settle time");

    secondary_wait_a: assert property (@(posedge pclk) disable iff (!presetn) // R15
        ($fell(pins.read_not_write) && !pins.mem_select_n && cmd.secondary) |->
            $past(!pins.mem_select_n) && $past(contention_n))
        else $error("secondary write started before contention settled");

    token_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // R24
        tok_write_end |-> pins.token_latch_select_n && pins.output_drive_n)
        else $error("token read back without update gap");

    acquire_poll_a: assert property (@(posedge pclk) disable iff (!presetn) // R25
        acq_reads_one |-> ##[1:6] token_read_pins)
        else $error("acquire did not poll after reading one");

    acquire_own_a: assert property (@(posedge pclk) disable iff (!presetn) // R25
        (capture && (op_reg == dpram_host_pkg::OP_TOKEN_ACQUIRE) && !dq_in[0]) |=>
            owned_reg ##1 (state_reg == dpram_host_pkg::ST_IDLE) && done_reg)
        else $error("zero read back did not end acquire with ownership");

endmodule // dpram_port_ctrl

// ===== bench/dpram_device_model.sv
`timescale 1ns/1ns
`include "dpram_host_defines.svh"

// One port of the shared memory; the far port is reduced to two inputs.
module dpram_device_model (
    input  wire dpram_host_pkg::pin_drive_t pins,
    input  wire logic                       far_hold,
    input  wire logic                       far_post,
    input  wire logic                       busy_n,
    output logic [`MEM_DATA_W-1:0]          dq,
    output logic                            int_n
);
    logic [`MEM_DATA_W-1:0]     mem [int];
    logic [7:0]                 own = 8'h00;
    logic [7:0]                 want = 8'h00;
    logic [2:0]                 ti;
    dpram_host_pkg::pin_drive_t prev = '1;

    initial dq = 9'h155;
    initial int_n = 1'b1;

    // A far write to our mailbox raises the flag unless contention blocks it.
    always @(posedge far_post) if (busy_n) int_n = 1'b0;

    // A pending request takes the latch the moment the far port lets go.
    always @(negedge far_hold) if (want[2]) {own[2], want[2]} = 2'b10;

    // Cycles take effect when their select is released.
    always @(pins)
    begin
        ti = prev.addr[2:0];
        if (!prev.mem_select_n && pins.mem_select_n && !prev.read_not_write && busy_n)
            mem[prev.addr] = prev.dq_out;
        if (!prev.mem_select_n && pins.mem_select_n && prev.addr == 17'h1FFFE && busy_n)
            int_n = prev.read_not_write ? 1'b1 : int_n;
        if (!prev.token_latch_select_n && pins.token_latch_select_n && !prev.read_not_write)
        begin
            if (prev.dq_out[0])
                {own[ti], want[ti]} = 2'b00;
            else if (ti == 3'h2 && far_hold)
                want[ti] = 1'b1;
            else
                own[ti] = 1'b1;
        end
        // Released lines show a changing value so stale data never reads as good.
        if (pins.read_not_write && !pins.output_drive_n && !pins.mem_select_n)
            dq = mem.exists(pins.addr) ? mem[pins.addr] : 9'h0AA;
        else if (pins.read_not_write && !pins.output_drive_n && !pins.token_latch_select_n)
            dq = {9{~own[pins.addr[2:0]]}};
        else
            dq = ~dq;
        prev = pins;
    end
endmodule // dpram_device_model

// ===== bench/testbench.sv
`timescale 1ns/1ns
`include "dpram_host_defines.svh"

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end

module testbench;
    logic                       pclk = 1'b0;
    logic                       presetn = 1'b0;
    logic                       psel = 1'b0;
    logic                       penable = 1'b0;
    logic                       pwrite = 1'b0;
    logic [11:0]                paddr = 12'h000;
    logic [31:0]                pwdata = 32'h0;
    logic [31:0]                prdata;
    logic [31:0]                rd;
    logic                       pready;
    logic                       pslverr;
    logic                       err;
    dpram_host_pkg::pin_drive_t pins;
    logic [8:0]                 dev_dq;
    logic                       int_n;
    logic                       busy_n = 1'b1;
    logic                       far_hold = 1'b0;
    logic                       far_post = 1'b0;
    int                         err_count = 0;
    int                         tests_run = 0;

    dpram_port_ctrl dpram_port_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .contention_n(busy_n),
        .dq_in(pins.dq_oe ? pins.dq_out : dev_dq), .mailbox_int_n(int_n));
    dpram_device_model dpram_device_model_i (.pins(pins), .far_hold(far_hold),
        .far_post(far_post), .busy_n(busy_n), .dq(dev_dq), .int_n(int_n));

    initial forever #10 pclk = ~pclk;

    // Both selects low at once is a forbidden pin combination.
    always @(posedge pclk) if (presetn && !pins.mem_select_n && !pins.token_latch_select_n)
        `CHK(1'b0, 1'b1)

    task automatic summarize();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // One transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20)
        begin
            err_count++;
            summarize();
        end
    endtask

    task automatic run_op(input logic [2:0] op, input logic [16:0] a, input logic [8:0] d);
        apb(1'b1, `REG_ADDR, {15'h0, a});
        apb(1'b1, `REG_WDATA, {23'h0, d});
        apb(1'b1, `REG_CTRL, {28'h0, op, 1'b1});
    endtask

    // Polls STATUS until done; a stuck sequencer ends the run.
    task automatic poll();
        int n;
        n = 0;
        rd = 32'h0;
        @(posedge pclk);
        while (rd[1] !== 1'b1 && n < 40)
        begin
            apb(1'b0, `REG_STATUS, 32'h0);
            n++;
        end
        if (n >= 40)
        begin
            err_count++;
            summarize();
        end
    endtask

    task automatic rd_back(input logic [2:0] op, input logic [16:0] a, input logic [8:0] e);
        run_op(op, a, 9'h000);
        poll();
        apb(1'b0, `REG_RDATA, 32'h0);
        `CHK(rd[8:0], e)
    endtask

    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h020, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0})
        run_op(3'h1, 17'h00005, 9'h1A5);
        poll();
        run_op(3'h1, 17'h10005, 9'h05A);
        poll();
        rd_back(3'h0, 17'h00005, 9'h1A5);
        run_op(3'h4, 17'h1FFF9, 9'h1FF);
        poll();
        `CHK(rd[2], 1'b1)
        rd_back(3'h2, 17'h00001, 9'h000);
        run_op(3'h3, 17'h00001, 9'h001);
        poll();
        rd_back(3'h2, 17'h08001, 9'h1FF);
        far_hold <= 1'b1;
        run_op(3'h4, 17'h00002, 9'h000);
        repeat (30) @(posedge pclk);
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHK(rd[2:1], 2'b00)
        far_hold <= 1'b0;
        poll();
        `CHK(rd[2], 1'b1)
        far_post <= 1'b1;
        rd_back(3'h0, 17'h1FFFF, 9'h0AA);
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHK(rd[4], 1'b1)
        rd_back(3'h0, 17'h1FFFE, 9'h0AA);
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHK(rd[4], 1'b0)
        busy_n <= 1'b0;
        apb(1'b1, `REG_CTRL, 32'h13);
        repeat (8) @(posedge pclk);
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHK(rd[3:0], 4'hD)
        apb(1'b1, `REG_CTRL, 32'h20);
        poll();
        summarize();
    end
endmodule // testbench
